// [pdm_channel_filter.sv]
// Purpose: One channel: counts PDM ones over a window and applies the gain code
// Assumes: bit_valid pulses once per captured microphone bit
// Notes: A coarse box decimator stands in for the real filter
`timescale 1ns/10ps
module pdm_channel_filter
  import pdm_mic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic [GAIN_W-1:0] gain_code,
  output logic [SAMPLE_W-1:0] sample,
  output logic sample_valid
);
  logic [DECIM_W-1:0] bit_count;
  logic [DECIM_W-1:0] ones;
  wire logic window_end = bit_valid && (bit_count == DECIM_W'(DECIM_LEN - 1));
  wire logic [DECIM_W-1:0] ones_total = ones + DECIM_W'(bit_in);
  wire logic [7:0] gain_index = 8'(gain_code) + GAIN_INDEX_OFFSET;
  wire logic [2:0] coarse = 3'(gain_index / STEPS_PER_SHIFT);
  wire logic [3:0] fine = 4'(gain_index % STEPS_PER_SHIFT);
  wire logic signed [7:0] centred = $signed({1'b0, ones_total}) - $signed(8'(DECIM_LEN / 2));
  logic [9:0] fine_mult;
  logic signed [31:0] scaled;

  // Twelve half-decibel steps make one doubling, so a shift covers the rest
  always_comb
  begin
    case (fine)
      4'h0: fine_mult = 10'h100;
      4'h1: fine_mult = 10'h10F;
      4'h2: fine_mult = 10'h11F;
      4'h3: fine_mult = 10'h130;
      4'h4: fine_mult = 10'h143;
      4'h5: fine_mult = 10'h156;
      4'h6: fine_mult = 10'h16A;
      4'h7: fine_mult = 10'h180;
      4'h8: fine_mult = 10'h196;
      4'h9: fine_mult = 10'h1AF;
      4'hA: fine_mult = 10'h1C8;
      default: fine_mult = 10'h1E3;
    endcase
    scaled = (32'(centred) * $signed({22'h0, fine_mult})) <<< coarse;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_count <= '0;
      ones <= '0;
      sample <= '0;
      sample_valid <= 1'b0;
    end
    else
    begin
      sample_valid <= window_end && !clear;
      if (clear || window_end)
      begin
        bit_count <= '0;
        ones <= '0;
      end
      else if (bit_valid)
      begin
        bit_count <= bit_count + DECIM_W'(1);
        ones <= ones_total;
      end
      if (window_end)
        sample <= SAMPLE_W'(scaled >>> GAIN_FRAC_SHIFT);
    end
  end
endmodule

// [pdm_mic_irq_mode_gain.sv]
// Purpose: APB register file, microphone clock, capture and RAM word packing
// Assumes: One or two PDM microphones sharing one data line
// Notes: Samples leave as packed 32-bit words with a one-cycle strobe
//
// Behaviour
// - Writing one to a bit of irq_enable_set turns that event's interrupt enable on, transfer-began at bit 0.
// - Writing one to a bit of irq_enable_clear turns that event's interrupt enable off, transfer-began at bit 0.
// - The transfer-halted enable sits at bit 1 of both registers with the same write-one behaviour.
// - The buffer-filled enable sits at bit 2 of both registers and a one written to clear disables it.
// - Reading either register returns the present enable bits, one meaning enabled.
// - In stereo each word holds right in the upper half and left in the lower half.
// - In mono each word holds two successive left samples, older low and newer high.
// - The edge field picks the clock edge for left or mono data, zero falling and one rising.
// - The gain codes step by half a decibel from -20 dB at code zero to +20 dB at the top code.
// - The middle gain code means no change and both gain registers reset to it.
// - The mode register resets to zero, stereo with left on the falling edge.
// - The buffer-filled event rises when the last sample of the buffer length, or after a stop, is written.
// - irq_enable_direct reads and writes the same enable bits that the set and clear registers change.
`timescale 1ns/10ps
module pdm_mic_irq_mode_gain
  import pdm_mic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mic_data,
  output logic mic_bit_clock,
  output logic [31:0] ram_word,
  output logic ram_word_valid,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_EVT-1:0] irq_enable;
  logic [NUM_EVT-1:0] irq_status;
  logic module_enable;
  logic [31:0] mic_clk_ctrl;
  logic [1:0] routing_mode;
  logic [GAIN_W-1:0] left_gain;
  logic [GAIN_W-1:0] right_gain;
  logic [BUF_LEN_W-1:0] buffer_len;
  run_state_type state;
  run_state_type next_state;

  wire logic setup_phase = psel && !penable;
  wire logic wr_access = psel && penable && pready && pwrite;
  wire logic wr_start = wr_access && paddr == OFS_TASK_START && pwdata[0];
  wire logic wr_stop = wr_access && paddr == OFS_TASK_STOP && pwdata[0];
  wire logic wr_direct = wr_access && paddr == OFS_IRQ_DIRECT;
  wire logic wr_set = wr_access && paddr == OFS_IRQ_SET;
  wire logic wr_clear = wr_access && paddr == OFS_IRQ_CLEAR;
  wire logic wr_status = wr_access && paddr == OFS_IRQ_STATUS;
  wire logic [NUM_EVT-1:0] wr_bits = pwdata[NUM_EVT-1:0];
  wire logic mono = routing_mode[MODE_OPERATION_BIT] == OP_MONO;
  wire logic left_edge_sel = routing_mode[MODE_EDGE_BIT];

  logic [31:0] read_value;
  logic addr_known;
  always_comb
  begin
    read_value = 32'h0;
    addr_known = 1'b1;
    case (paddr)
      OFS_TASK_START, OFS_TASK_STOP: read_value = 32'h0;
      OFS_EVT_STARTED: read_value = 32'(irq_status[EVT_STARTED]);
      OFS_EVT_HALTED: read_value = 32'(irq_status[EVT_HALTED]);
      OFS_EVT_FILLED: read_value = 32'(irq_status[EVT_FILLED]);
      OFS_IRQ_DIRECT, OFS_IRQ_SET, OFS_IRQ_CLEAR: read_value = 32'(irq_enable);
      OFS_IRQ_STATUS: read_value = 32'(irq_status);
      OFS_MODULE_ENABLE: read_value = 32'(module_enable);
      OFS_MIC_CLK_CTRL: read_value = mic_clk_ctrl;
      OFS_ROUTING_MODE: read_value = 32'(routing_mode);
      OFS_LEFT_GAIN: read_value = 32'(left_gain);
      OFS_RIGHT_GAIN: read_value = 32'(right_gain);
      OFS_BUFFER_LEN: read_value = 32'(buffer_len);
      default: addr_known = 1'b0;
    endcase
  end

  // Zero wait states: read data is caught in the setup cycle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup_phase)
      begin
        prdata <= pwrite ? 32'h0 : read_value;
        pslverr <= !addr_known;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables: direct write first, then set, then clear
  logic [NUM_EVT-1:0] next_irq_enable;
  always_comb
  begin
    next_irq_enable = wr_direct ? wr_bits : irq_enable;
    next_irq_enable = next_irq_enable | (wr_set ? wr_bits : '0);
    next_irq_enable = next_irq_enable & ~(wr_clear ? wr_bits : '0);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_enable <= '0;
      module_enable <= 1'b0;
      mic_clk_ctrl <= 32'h0;
      routing_mode <= MODE_RESET;
      left_gain <= unity_gain_code;
      right_gain <= unity_gain_code;
      buffer_len <= '0;
    end
    else
    begin
      irq_enable <= next_irq_enable;
      if (wr_access && paddr == OFS_MODULE_ENABLE)
        module_enable <= pwdata[0];
      if (wr_access && paddr == OFS_MIC_CLK_CTRL)
        mic_clk_ctrl <= pwdata;
      if (wr_access && paddr == OFS_ROUTING_MODE)
        routing_mode <= pwdata[MODE_EDGE_BIT:MODE_OPERATION_BIT];
      if (wr_access && paddr == OFS_LEFT_GAIN)
        left_gain <= pwdata[GAIN_W-1:0];
      if (wr_access && paddr == OFS_RIGHT_GAIN)
        right_gain <= pwdata[GAIN_W-1:0];
      if (wr_access && paddr == OFS_BUFFER_LEN)
        buffer_len <= pwdata[BUF_LEN_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microphone clock and bit capture
  logic [MIC_HALF_W-1:0] half_count;
  logic data_meta;
  logic data_sync;
  wire logic running = state != ST_IDLE;
  wire logic half_done = running && half_count == MIC_HALF_W'(MIC_HALF_CYCLES - 1);
  wire logic edge_rise = half_done && !mic_bit_clock;
  wire logic edge_fall = half_done && mic_bit_clock;
  // Left sits on the chosen edge, right on the other
  wire logic left_strobe = left_edge_sel == left_on_rising ? edge_rise : edge_fall;
  wire logic right_strobe = left_edge_sel == left_on_rising ? edge_fall : edge_rise;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      half_count <= '0;
      mic_bit_clock <= 1'b0;
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end
    else
    begin
      data_meta <= mic_data;
      data_sync <= data_meta;
      half_count <= half_done || !running ? '0 : half_count + MIC_HALF_W'(1);
      mic_bit_clock <= running ? mic_bit_clock ^ half_done : 1'b0;
    end
  end

  logic [SAMPLE_W-1:0] left_sample;
  logic [SAMPLE_W-1:0] right_sample;
  logic left_valid;
  logic right_valid;
  logic [1:0] strobe_vec;
  logic [1:0] valid_vec;
  logic [GAIN_W-1:0] gain_vec [2];
  logic [SAMPLE_W-1:0] sample_vec [2];
  assign strobe_vec = {right_strobe, left_strobe};
  assign gain_vec[0] = left_gain;
  assign gain_vec[1] = right_gain;
  assign left_sample = sample_vec[0];
  assign right_sample = sample_vec[1];
  assign left_valid = valid_vec[0];
  assign right_valid = valid_vec[1];

  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
      pdm_channel_filter u_filter (
        .core_clk(core_clk),
        .rstn(rstn),
        .clear(!running),
        .bit_valid(strobe_vec[ch]),
        .bit_in(data_sync),
        .gain_code(gain_vec[ch]),
        .sample(sample_vec[ch]),
        .sample_valid(valid_vec[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Word packing and transfer sequencing
  logic [SAMPLE_W-1:0] held_left;
  logic held_valid;
  logic [BUF_LEN_W:0] sample_count;
  logic stop_pending;
  wire logic word_stereo = !mono && held_valid && right_valid;
  wire logic word_mono = mono && held_valid && left_valid;
  wire logic word_out = word_stereo || word_mono;
  wire logic [31:0] packed_word = mono ? {left_sample, held_left} : {right_sample, held_left};
  wire logic [BUF_LEN_W:0] count_after = sample_count + (BUF_LEN_W+1)'(2);
  wire logic buffer_full = word_out && count_after >= {1'b0, buffer_len};
  wire logic filled_evt = word_out && (buffer_full || stop_pending);
  wire logic halted_evt = state == ST_DRAIN && filled_evt;
  wire logic started_evt = state == ST_IDLE && wr_start && module_enable;

  always_comb
  begin
    case (state)
      ST_IDLE: next_state = started_evt ? ST_RUN : ST_IDLE;
      ST_RUN: next_state = wr_stop || !module_enable ? ST_DRAIN : ST_RUN;
      ST_DRAIN: next_state = filled_evt || !module_enable ? ST_IDLE : ST_DRAIN;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      held_left <= '0;
      held_valid <= 1'b0;
      sample_count <= '0;
      stop_pending <= 1'b0;
      ram_word <= 32'h0;
      ram_word_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      stop_pending <= next_state == ST_DRAIN;
      ram_word_valid <= word_out;
      if (word_out)
        ram_word <= packed_word;
      if (!running || word_out)
        held_valid <= 1'b0;
      else if (left_valid && !held_valid)
        held_valid <= 1'b1;
      if (left_valid && (!held_valid || word_out))
        held_left <= left_sample;
      if (!running || filled_evt)
        sample_count <= '0;
      else if (word_out)
        sample_count <= count_after;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events win over a clear in the same cycle
  wire logic [NUM_EVT-1:0] event_hits = {filled_evt, halted_evt, started_evt};
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~(wr_status ? wr_bits : '0)) | event_hits;
      irq <= |(irq_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_set_enables;
    @(posedge core_clk) disable iff (!rstn)
      wr_set && !wr_clear |=> (irq_enable & $past(wr_bits)) == $past(wr_bits);
  endproperty
  a_set_enables: assert property (p_set_enables) else $error("set write missed enable");
  property p_clear_enables;
    @(posedge core_clk) disable iff (!rstn)
      wr_clear |=> (irq_enable & $past(wr_bits)) == '0;
  endproperty
  a_clear_enables: assert property (p_clear_enables) else $error("clear write left enable");
  property p_read_enables;
    @(posedge core_clk) disable iff (!rstn)
      setup_phase && !pwrite && (paddr == OFS_IRQ_SET || paddr == OFS_IRQ_CLEAR)
      |=> prdata == 32'($past(irq_enable));
  endproperty
  a_read_enables: assert property (p_read_enables) else $error("enable readback wrong");
  property p_stereo_pack;
    @(posedge core_clk) disable iff (!rstn)
      word_stereo |=> ram_word_valid && ram_word[31:16] == $past(right_sample);
  endproperty
  a_stereo_pack: assert property (p_stereo_pack) else $error("stereo right half wrong");
  property p_mono_pack;
    @(posedge core_clk) disable iff (!rstn)
      word_mono |=> ram_word == {$past(left_sample), $past(held_left)};
  endproperty
  a_mono_pack: assert property (p_mono_pack) else $error("mono packing wrong");
  // The clock must land on the chosen level right after a left capture
  property p_edge_select;
    @(posedge core_clk) disable iff (!rstn)
      left_strobe |=> mic_bit_clock == $past(left_edge_sel);
  endproperty
  a_edge_select: assert property (p_edge_select) else $error("left captured on wrong edge");
  property p_filled_event;
    @(posedge core_clk) disable iff (!rstn)
      filled_evt |=> ram_word_valid && irq_status[EVT_FILLED];
  endproperty
  a_filled_event: assert property (p_filled_event) else $error("filled event missing");
  property p_irq_level;
    @(posedge core_clk) disable iff (!rstn)
      |(irq_status & irq_enable) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
  property p_gain_reset;
    @(posedge core_clk) disable iff (!rstn)
      $rose(rstn) |-> left_gain == unity_gain_code && right_gain == unity_gain_code && routing_mode == MODE_RESET;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain or mode not at reset value");
  c_stereo_word: cover property (@(posedge core_clk) disable iff (!rstn) word_stereo);
  c_mono_word: cover property (@(posedge core_clk) disable iff (!rstn) word_mono);
  c_halted: cover property (@(posedge core_clk) disable iff (!rstn) halted_evt);
  c_irq: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irq));
endmodule

// [pdm_mic_pair_model.sv]
// Purpose: Two PDM microphones sharing one data line
// Assumes: Left mic drives while the bit clock is high, right mic while it is low
// Notes: Each mic sends a fixed level, so its density is fully on or fully off
`timescale 1ns/10ps
module pdm_mic_pair_model
(
  input wire logic mic_bit_clock,
  input wire logic left_level,
  input wire logic right_level,
  output logic mic_data
);
  logic drive_level;

  ////////////////////////////////////////////////////////////////////////////
  // Data follows a clock edge late, well inside the allowed valid window
  assign drive_level = mic_bit_clock ? left_level : right_level;

  initial
  begin
    mic_data = 1'b0;
  end

  always @(drive_level)
  begin
    mic_data <= #20 drive_level;
  end
endmodule

// [pdm_mic_pkg.sv]
// Purpose: Shared constants for the PDM microphone receiver control block
// Assumes: APB with 32-bit data, core clock of 125 MHz
// Notes: Offsets are byte addresses
package pdm_mic_pkg;
  localparam logic [11:0] OFS_TASK_START = 12'h000;
  localparam logic [11:0] OFS_TASK_STOP = 12'h004;
  localparam logic [11:0] OFS_EVT_STARTED = 12'h100;
  localparam logic [11:0] OFS_EVT_HALTED = 12'h104;
  localparam logic [11:0] OFS_EVT_FILLED = 12'h108;
  localparam logic [11:0] OFS_IRQ_DIRECT = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h308;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h310;
  localparam logic [11:0] OFS_MODULE_ENABLE = 12'h500;
  localparam logic [11:0] OFS_MIC_CLK_CTRL = 12'h504;
  localparam logic [11:0] OFS_ROUTING_MODE = 12'h508;
  localparam logic [11:0] OFS_LEFT_GAIN = 12'h518;
  localparam logic [11:0] OFS_RIGHT_GAIN = 12'h51C;
  localparam logic [11:0] OFS_BUFFER_LEN = 12'h564;

  localparam int EVT_STARTED = 0;
  localparam int EVT_HALTED = 1;
  localparam int EVT_FILLED = 2;
  localparam int NUM_EVT = 3;

  localparam int MODE_OPERATION_BIT = 0;
  localparam int MODE_EDGE_BIT = 1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic OP_STEREO = 1'b0;
  localparam logic OP_MONO = 1'b1;
  localparam logic left_on_falling = 1'b0;
  localparam logic left_on_rising = 1'b1;

  localparam int GAIN_W = 7;
  localparam logic [GAIN_W-1:0] lowest_gain_code = 7'h00;
  localparam logic [GAIN_W-1:0] unity_gain_code = 7'h28;
  localparam logic [GAIN_W-1:0] highest_gain_code = 7'h50;
  localparam logic [7:0] GAIN_INDEX_OFFSET = 8'h08;
  localparam logic [7:0] STEPS_PER_SHIFT = 8'h0C;
  localparam int GAIN_FRAC_SHIFT = 7;

  localparam int BUF_LEN_W = 15;
  localparam int SAMPLE_W = 16;
  localparam int DECIM_LEN = 64;
  localparam int DECIM_W = 7;

  localparam int CORE_CLK_HZ = 125000000;
  localparam int MIC_CLK_HZ = 1024000;
  localparam int MIC_HALF_CYCLES = CORE_CLK_HZ / (2 * MIC_CLK_HZ);
  localparam int MIC_HALF_W = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DRAIN = 2'b11
  } run_state_type;
endpackage

// [tb.sv]
// Purpose: Self-checking bench for the PDM receiver control block
// Assumes: Zero-wait APB slave, mic pair model on the data line
// Notes: Checks the second stereo word and the first word of the edge and mono runs, since only sign and size are predictable
`timescale 1ns/10ps
module tb
  import pdm_mic_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mic_data;
  logic mic_bit_clock;
  logic [31:0] ram_word;
  logic ram_word_valid;
  logic irq;
  logic [31:0] rd;
  logic [31:0] w;
  logic er;
  int err_count = 0;
  int cmp_count = 0;

  always #4 core_clk = ~core_clk;

  pdm_mic_irq_mode_gain DUT (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mic_data(mic_data), .mic_bit_clock(mic_bit_clock), .ram_word(ram_word),
    .ram_word_valid(ram_word_valid), .irq(irq));

  pdm_mic_pair_model mics (.mic_bit_clock(mic_bit_clock), .left_level(1'b1), .right_level(1'b0),
    .mic_data(mic_data));

  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a slave that never answers
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write error flag", 32'h0, {31'h0, er});
  endtask

  task rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task wait_word;
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ram_word_valid !== 1'b1 && n < 20000);
    w = ram_word;
    chk("word strobe", 32'h1, {31'h0, ram_word_valid});
  endtask

  task wait_irq(input logic exp);
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (irq !== exp && n < 20);
    chk("irq level", {31'h0, exp}, {31'h0, irq});
  endtask

  // Core cycles between two toggles of the running bit clock
  task chk_half_period;
    logic lvl;
    int n;
    lvl = mic_bit_clock;
    n = 0;
    do
    begin
      @(posedge core_clk);
    end
    while (mic_bit_clock === lvl);
    lvl = mic_bit_clock;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (mic_bit_clock === lvl && n < 200);
    chk("bit clock half period", MIC_HALF_CYCLES, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdchk("enable set reset", OFS_IRQ_SET, 32'h0);
    rdchk("enable clear reset", OFS_IRQ_CLEAR, 32'h0);
    rdchk("mode reset", OFS_ROUTING_MODE, 32'h0);
    rdchk("left gain reset", OFS_LEFT_GAIN, 32'h28);
    rdchk("right gain reset", OFS_RIGHT_GAIN, 32'h28);
    chk("idle bit clock", 32'h0, {31'h0, mic_bit_clock});
  endtask

  task t_enables;
    for (int b = 0; b < NUM_EVT; b++)
    begin
      wr(OFS_IRQ_SET, 32'h1 << b);
      rdchk("set read", OFS_IRQ_SET, 32'h1 << b);
      rdchk("clear read", OFS_IRQ_CLEAR, 32'h1 << b);
      rdchk("direct read", OFS_IRQ_DIRECT, 32'h1 << b);
      wr(OFS_IRQ_CLEAR, 32'h1 << b);
      rdchk("after clear", OFS_IRQ_SET, 32'h0);
    end
    wr(OFS_IRQ_DIRECT, 32'h5);
    wr(OFS_IRQ_SET, 32'h2);
    rdchk("set keeps others", OFS_IRQ_SET, 32'h7);
    wr(OFS_IRQ_CLEAR, 32'h4);
    rdchk("clear keeps others", OFS_IRQ_DIRECT, 32'h3);
  endtask

  task t_unmapped;
    apb(1'b0, 12'h7F0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
  endtask

  task t_stereo;
    wr(OFS_LEFT_GAIN, 32'h50);
    rdchk("left gain top", OFS_LEFT_GAIN, 32'h50);
    wr(OFS_RIGHT_GAIN, 32'h00);
    rdchk("right gain bottom", OFS_RIGHT_GAIN, 32'h00);
    wr(OFS_MODULE_ENABLE, 32'h1);
    wr(OFS_BUFFER_LEN, 32'h4);
    wr(OFS_IRQ_SET, 32'h7);
    wr(OFS_TASK_START, 32'h1);
    wait_irq(1'b1);
    rdchk("started flag", OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    wait_irq(1'b0);
    wait_word;
    wait_word;
    chk("left half positive", 32'h1, {31'h0, $signed(w[15:0]) > 0});
    chk("right half negative", 32'h1, {31'h0, w[31]});
    chk("gain order", 32'h1, {31'h0, $signed(w[15:0]) > -$signed(w[31:16])});
    rdchk("filled at length", OFS_IRQ_STATUS, 32'h4);
    wr(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_TASK_STOP, 32'h1);
    wait_word;
    rdchk("filled after stop", OFS_IRQ_STATUS, 32'h6);
    wr(OFS_IRQ_STATUS, 32'h7);
  endtask

  task t_edge;
    wr(OFS_ROUTING_MODE, 32'h2);
    rdchk("mode rising", OFS_ROUTING_MODE, 32'h2);
    wr(OFS_IRQ_CLEAR, 32'h1);
    wr(OFS_TASK_START, 32'h1);
    rdchk("masked started flag", OFS_IRQ_STATUS, 32'h1);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_STATUS, 32'h7);
    wait_word;
    chk("left takes low phase", 32'h1, {31'h0, w[15]});
    chk("right takes high phase", 32'h1, {31'h0, $signed(w[31:16]) > 0});
    chk_half_period;
    wr(OFS_TASK_STOP, 32'h1);
    wait_word;
    wr(OFS_IRQ_STATUS, 32'h7);
  endtask

  task t_mono;
    wr(OFS_ROUTING_MODE, 32'h1);
    wr(OFS_TASK_START, 32'h1);
    wait_word;
    chk("older left positive", 32'h1, {31'h0, $signed(w[15:0]) > 0});
    chk("newer left equal", {16'h0, w[15:0]}, {16'h0, w[31:16]});
    wr(OFS_TASK_STOP, 32'h1);
    wait_word;
    wr(OFS_IRQ_STATUS, 32'h7);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Seven words, four at roughly 7800 cycles and the first stereo one and the two mono ones at roughly 15600 each, fit inside this span
  initial
  begin
    #800000;
    err_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    finish_test;
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset;
    t_enables;
    t_unmapped;
    t_stereo;
    t_edge;
    t_mono;
    finish_test;
  end
endmodule
